/* File: hw/tmr_params.svh */
// Constant definitions for the 16-bit timer/event counter.
`ifndef TMR_PARAMS_SVH
`define TMR_PARAMS_SVH
`define TMR_OFF_COUNTER 8'h00
`define TMR_OFF_CCA 8'h04
`define TMR_OFF_CCB 8'h08
`define TMR_OFF_MODE 8'h0C
`define TMR_OFF_CCCTL 8'h10
`define TMR_OFF_PRESC 8'h14
`define TMR_OFF_OUTCTL 8'h18
`define TMR_OVF_BIT 0
`define TMR_RUN_LSB 2
`define TMR_CCB_CAP_BIT 2
`define TMR_CLK_LSB 0
`define TMR_EDGE_LSB 4
`define TMR_OE_BIT 0
`define TMR_TOGA_BIT 1
`define TMR_TOGB_BIT 4
`define TMR_OSEN_BIT 5
`define TMR_OSPT_BIT 6
`define TMR_LEVEL_BIT 8
`define TMR_CNT_MAX 16'hFFFF
`define TMR_CC_RST 16'h0000
`define TMR_RESP_OKAY 2'h0
`define TMR_RESP_SLVERR 2'h2
`define TMR_DIV_MID_LOG2 2
`define TMR_DIV_HI_LOG2 8
`endif

/* File: hw/tmr_pkg.sv */
// Types shared by the timer/event counter modules.
package tmr_pkg;
   typedef enum logic [1:0] {tmr_run_stop, tmr_run_free, tmr_run_restart, tmr_run_match} tmr_run_t;
   typedef enum logic [1:0] {tmr_edge_fall, tmr_edge_rise, tmr_edge_none, tmr_edge_both} tmr_edge_t;
   typedef enum logic [1:0] {tmr_clk_base, tmr_clk_mid, tmr_clk_slow, tmr_clk_event} tmr_clk_t;
endpackage

/* File: hw/tmr_prescaler.sv */
// Count clock selection: base clock, two divided rates or filtered trigger edges.
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_prescaler #(
   parameter int DIV_MID_LOG2 = `TMR_DIV_MID_LOG2,
   parameter int DIV_HI_LOG2 = `TMR_DIV_HI_LOG2
) (
   // Clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic run,
   input wire tmr_pkg::tmr_clk_t sel,
   // Event source and result
   input wire logic ext_tick,
   output logic tick
);
   import tmr_pkg::*;
   logic [DIV_HI_LOG2-1:0] div_cnt;

   // The divider restarts with the timer so the first count clock comes a fixed time after start.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         div_cnt <= '0;
      else if (ce)
      begin
         if (!run)
            div_cnt <= '0;
         else
            div_cnt <= div_cnt + 1'b1;
      end
   end

   always_comb
   begin
      case (sel)
         tmr_clk_base: tick = 1'b1;
         tmr_clk_mid: tick = &div_cnt[DIV_MID_LOG2-1:0];
         tmr_clk_slow: tick = &div_cnt;
         tmr_clk_event: tick = ext_tick;
         default: tick = 1'b0;
      endcase
   end
endmodule

/* File: hw/tmr_edge_filter.sv */
// Two-sample noise filter and edge detector for the synchronised trigger input.
`timescale 1ns/1ps
module tmr_edge_filter (
   // Clock and control
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic sample_en,
   input wire tmr_pkg::tmr_edge_t edge_sel,
   // Signal
   input wire logic din,
   output logic edge_hit
);
   import tmr_pkg::*;
   logic last_sample;
   logic level;

   // A new level is taken only when two successive samples agree, so pulses shorter than one
   // sample period never reach the counter.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         last_sample <= 1'b0;
         level <= 1'b0;
         edge_hit <= 1'b0;
      end
      else if (ce)
      begin
         edge_hit <= 1'b0;
         if (sample_en)
         begin
            last_sample <= din;
            if (din == last_sample && din != level)
            begin
               level <= din;
               case (edge_sel)
                  tmr_edge_rise: edge_hit <= din;
                  tmr_edge_fall: edge_hit <= !din;
                  tmr_edge_both: edge_hit <= 1'b1;
                  default: edge_hit <= 1'b0;
               endcase
            end
         end
      end
   end
endmodule

/* File: hw/tmr_top.sv */
// 16-bit timer/event counter with capture, compare, square wave and one-shot output, on AXI4-Lite.
//
// Local design decisions: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "tmr_params.svh"
module tmr_top #(
   parameter int ADDR_W = 8
) (
   // Clock, reset, enable
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   // AXI4-Lite write
   input wire logic [ADDR_W-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read
   input wire logic [ADDR_W-1:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Pins and events
   input wire logic trigger_input,
   output logic timer_output_pin,
   output logic match_a_irq,
   output logic match_b_irq
);
   import tmr_pkg::*;

   logic [15:0] main_counter;
   logic [15:0] compare_capture_a;
   logic [15:0] compare_capture_b;
   tmr_run_t run_mode_bits;
   logic overflow_flag;
   logic cc_b_capture;
   tmr_clk_t count_clk_sel;
   tmr_edge_t edge_select_bits;
   logic output_enable_bit;
   logic toggle_on_match_a_bit;
   logic toggle_on_match_b;
   logic oneshot_enable;
   logic out_level;
   logic armed;
   logic aw_have;
   logic w_have;
   logic [ADDR_W-1:0] aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0] w_strb_q;
   logic trig_meta;
   logic trig_sync;
   logic evt_edge;
   logic cap_edge;
   logic tick;
   logic running;
   logic wr_fire;
   logic ospt_wr;
   logic trig_restart;
   logic capture_b;
   logic match_a;
   logic match_b;
   logic start_match;
   logic end_match;
   logic [15:0] next_counter;
   logic next_level;

   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
      addr_ok = a == `TMR_OFF_COUNTER || a == `TMR_OFF_CCA || a == `TMR_OFF_CCB || a == `TMR_OFF_MODE ||
                a == `TMR_OFF_CCCTL || a == `TMR_OFF_PRESC || a == `TMR_OFF_OUTCTL;
   endfunction

   // The trigger pin is asynchronous, so it passes two flip-flops first.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
      end
      else if (ce)
      begin
         trig_meta <= trigger_input;
         trig_sync <= trig_meta;
      end
   end

   // Event counting samples at the undivided clock.
   tmr_edge_filter u_evt_filter (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .sample_en(running),
      .edge_sel(edge_select_bits), .din(trig_sync), .edge_hit(evt_edge)
   );

   // Capture and restart sample at the selected count clock.
   tmr_edge_filter u_cap_filter (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .sample_en(running && tick),
      .edge_sel(edge_select_bits), .din(trig_sync), .edge_hit(cap_edge)
   );

   tmr_prescaler u_presc (
      .aclk(aclk), .aresetn(aresetn), .ce(ce), .run(running),
      .sel(count_clk_sel), .ext_tick(evt_edge), .tick(tick)
   );

   assign running = run_mode_bits != tmr_run_stop;
   assign wr_fire = aw_have && w_have && !bvalid;
   assign ospt_wr = wr_fire && running && aw_addr_q == `TMR_OFF_OUTCTL && w_strb_q[0] &&
                    w_data_q[`TMR_OSPT_BIT];
   assign trig_restart = running && cap_edge && !(armed && oneshot_enable) &&
                         (run_mode_bits == tmr_run_restart || (run_mode_bits == tmr_run_free && oneshot_enable));
   assign capture_b = running && cc_b_capture && cap_edge &&
                      (run_mode_bits == tmr_run_restart || run_mode_bits == tmr_run_free);
   assign match_a = running && tick && main_counter == compare_capture_a;
   assign match_b = running && tick && !cc_b_capture && main_counter == compare_capture_b;
   assign start_match = (compare_capture_b < compare_capture_a) ? match_b : match_a;
   assign end_match = (compare_capture_b < compare_capture_a) ? match_a : match_b;

   // AXI4-Lite write channels; address and data are taken in either order.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready <= 1'b1;
         wready <= 1'b1;
         aw_have <= 1'b0;
         w_have <= 1'b0;
         aw_addr_q <= '0;
         w_data_q <= 32'h00000000;
         w_strb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `TMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (awvalid && awready)
         begin
            aw_addr_q <= awaddr;
            aw_have <= 1'b1;
            awready <= 1'b0;
         end
         if (wvalid && wready)
         begin
            w_data_q <= wdata;
            w_strb_q <= wstrb;
            w_have <= 1'b1;
            wready <= 1'b0;
         end
         if (wr_fire)
         begin
            aw_have <= 1'b0;
            w_have <= 1'b0;
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b1;
            bresp <= addr_ok(aw_addr_q) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
         end
         else if (bvalid && bready)
            bvalid <= 1'b0;
      end
   end

   // AXI4-Lite read channel; data is latched when the address is taken.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         arready <= 1'b1;
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `TMR_RESP_OKAY;
      end
      else if (ce)
      begin
         if (arvalid && arready)
         begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rresp <= addr_ok(araddr) ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
            case (araddr)
               `TMR_OFF_COUNTER: rdata <= {16'h0000, main_counter};
               `TMR_OFF_CCA: rdata <= {16'h0000, compare_capture_a};
               `TMR_OFF_CCB: rdata <= {16'h0000, compare_capture_b};
               `TMR_OFF_MODE: rdata <= {28'h0000000, run_mode_bits, 1'b0, overflow_flag};
               `TMR_OFF_CCCTL: rdata <= {29'h00000000, cc_b_capture, 2'h0};
               `TMR_OFF_PRESC: rdata <= {26'h0000000, edge_select_bits, 2'h0, count_clk_sel};
               `TMR_OFF_OUTCTL: rdata <= {23'h000000, out_level, 2'h0, oneshot_enable, toggle_on_match_b,
                                         2'h0, toggle_on_match_a_bit, output_enable_bit};
               default: rdata <= 32'h00000000;
            endcase
         end
         else if (rvalid && rready)
         begin
            rvalid <= 1'b0;
            arready <= 1'b1;
         end
      end
   end

   // Configuration registers; the trigger bit is a pulse and never stored.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         run_mode_bits <= tmr_run_stop;
         cc_b_capture <= 1'b0;
         count_clk_sel <= tmr_clk_base;
         edge_select_bits <= tmr_edge_fall;
         output_enable_bit <= 1'b0;
         toggle_on_match_a_bit <= 1'b0;
         toggle_on_match_b <= 1'b0;
         oneshot_enable <= 1'b0;
         compare_capture_a <= `TMR_CC_RST;
      end
      else if (ce && wr_fire && w_strb_q[0])
      begin
         case (aw_addr_q)
            `TMR_OFF_MODE: run_mode_bits <= tmr_run_t'(w_data_q[`TMR_RUN_LSB +: 2]);
            `TMR_OFF_CCCTL: cc_b_capture <= w_data_q[`TMR_CCB_CAP_BIT];
            `TMR_OFF_PRESC:
            begin
               count_clk_sel <= tmr_clk_t'(w_data_q[`TMR_CLK_LSB +: 2]);
               edge_select_bits <= tmr_edge_t'(w_data_q[`TMR_EDGE_LSB +: 2]);
            end
            `TMR_OFF_OUTCTL:
            begin
               output_enable_bit <= w_data_q[`TMR_OE_BIT];
               toggle_on_match_a_bit <= w_data_q[`TMR_TOGA_BIT];
               toggle_on_match_b <= w_data_q[`TMR_TOGB_BIT];
               oneshot_enable <= w_data_q[`TMR_OSEN_BIT];
            end
            `TMR_OFF_CCA: compare_capture_a <= merge16(compare_capture_a, w_data_q, w_strb_q);
            default: run_mode_bits <= run_mode_bits;
         endcase
      end
      else if (ce && wr_fire && w_strb_q[1] && aw_addr_q == `TMR_OFF_CCA)
         compare_capture_a <= merge16(compare_capture_a, w_data_q, w_strb_q);
   end

   // A capture takes priority over a software write in the same cycle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         compare_capture_b <= `TMR_CC_RST;
      else if (ce)
      begin
         if (capture_b)
            compare_capture_b <= main_counter;
         else if (wr_fire && aw_addr_q == `TMR_OFF_CCB)
            compare_capture_b <= merge16(compare_capture_b, w_data_q, w_strb_q);
      end
   end

   always_comb
   begin
      if (!running)
         next_counter = 16'h0000;
      else if (ospt_wr || trig_restart)
         next_counter = 16'h0000;
      else if (tick && run_mode_bits == tmr_run_match && main_counter == compare_capture_a)
         next_counter = 16'h0000;
      else if (tick)
         next_counter = main_counter + 16'h0001;
      else
         next_counter = main_counter;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         main_counter <= 16'h0000;
      else if (ce)
         main_counter <= next_counter;
   end

   // A new overflow wins over a software clear in the same cycle.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         overflow_flag <= 1'b0;
      else if (ce)
      begin
         if (running && tick && main_counter == `TMR_CNT_MAX && !ospt_wr && !trig_restart)
            overflow_flag <= 1'b1;
         else if (wr_fire && aw_addr_q == `TMR_OFF_MODE && w_strb_q[0] && !w_data_q[`TMR_OVF_BIT])
            overflow_flag <= 1'b0;
      end
   end

   // A pulse is armed by either trigger and disarmed by the closing match.
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         armed <= 1'b0;
      else if (ce)
      begin
         if (!running || !oneshot_enable)
            armed <= 1'b0;
         else if (ospt_wr || trig_restart)
            armed <= 1'b1;
         else if (end_match)
            armed <= 1'b0;
      end
   end

   always_comb
   begin
      next_level = out_level;
      if (oneshot_enable)
      begin
         if (armed && start_match)
            next_level = 1'b1;
         else if (armed && end_match)
            next_level = 1'b0;
      end
      else
         next_level = out_level ^ (match_a && toggle_on_match_a_bit) ^ (match_b && toggle_on_match_b);
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_level <= 1'b0;
         timer_output_pin <= 1'b0;
         match_a_irq <= 1'b0;
         match_b_irq <= 1'b0;
      end
      else if (ce)
      begin
         out_level <= next_level;
         timer_output_pin <= output_enable_bit && next_level;
         match_a_irq <= match_a;
         match_b_irq <= match_b || capture_b;
      end
   end

   property p_restart_capture;
      @(posedge aclk) disable iff (!aresetn)
      ce && capture_b && trig_restart && !ospt_wr
      |=> compare_capture_b == $past(main_counter) && main_counter == 16'h0000;
   endproperty
   a_restart_capture: assert property (p_restart_capture) else $error("restart capture wrong");

   property p_event_inc;
      @(posedge aclk) disable iff (!aresetn)
      ce && count_clk_sel == tmr_clk_event && running && evt_edge && !ospt_wr && !trig_restart
      && main_counter != `TMR_CNT_MAX && !(run_mode_bits == tmr_run_match && main_counter == compare_capture_a)
      |=> main_counter == $past(main_counter) + 16'h0001;
   endproperty
   a_event_inc: assert property (p_event_inc) else $error("event not counted");

   property p_match_clear;
      @(posedge aclk) disable iff (!aresetn)
      ce && run_mode_bits == tmr_run_match && tick && main_counter == compare_capture_a && !ospt_wr
      |=> main_counter == 16'h0000 && match_a_irq;
   endproperty
   a_match_clear: assert property (p_match_clear) else $error("match clear missing");

   property p_ovf_cause;
      @(posedge aclk) disable iff (!aresetn)
      $rose(overflow_flag) |-> $past(main_counter) == `TMR_CNT_MAX && $past(tick);
   endproperty
   a_ovf_cause: assert property (p_ovf_cause) else $error("overflow without wrap");

   property p_square_toggle;
      @(posedge aclk) disable iff (!aresetn)
      ce && !oneshot_enable && match_a && toggle_on_match_a_bit && !(match_b && toggle_on_match_b)
      |=> out_level != $past(out_level);
   endproperty
   a_square_toggle: assert property (p_square_toggle) else $error("output not toggled");

   property p_ospt_start;
      @(posedge aclk) disable iff (!aresetn)
      ce && ospt_wr && oneshot_enable |=> main_counter == 16'h0000 && armed;
   endproperty
   a_ospt_start: assert property (p_ospt_start) else $error("software trigger ignored");

   property p_pulse_on;
      @(posedge aclk) disable iff (!aresetn)
      ce && oneshot_enable && armed && compare_capture_b < compare_capture_a && match_b |=> out_level;
   endproperty
   a_pulse_on: assert property (p_pulse_on) else $error("pulse not started");

   property p_ext_ignored;
      @(posedge aclk) disable iff (!aresetn)
      ce && armed && oneshot_enable && (run_mode_bits == tmr_run_restart || run_mode_bits == tmr_run_free)
      && cap_edge && !ospt_wr && !(wr_fire && aw_addr_q == `TMR_OFF_MODE)
      && main_counter != `TMR_CNT_MAX && main_counter != 16'h0000 |=> main_counter != 16'h0000;
   endproperty
   a_ext_ignored: assert property (p_ext_ignored) else $error("retrigger not ignored");

   property p_stopped;
      @(posedge aclk) disable iff (!aresetn)
      ce && run_mode_bits == tmr_run_stop |=> main_counter == 16'h0000 && !armed;
   endproperty
   a_stopped: assert property (p_stopped) else $error("counter runs while stopped");
endmodule

/* File: test/tmr_pulse_src.sv */
// Trigger pulse source and output width meter facing the timer pins.
`timescale 1ns/1ps
module tmr_pulse_src (
   // Clock
   input wire logic aclk,
   // Pins
   input wire logic timer_output_pin,
   output logic trigger_input
);
   int cyc = 0;
   int last_t = 0;
   int gap = 0;
   int hi_w = 0;
   logic prev = 1'b0;
   initial trigger_input = 1'b0;
   // Levels are held whole cycles, so a short pulse is a deliberate glitch.
   task automatic pulse(input int hi, input int lo);
      trigger_input <= 1'b1;
      repeat (hi) @(posedge aclk);
      trigger_input <= 1'b0;
      repeat (lo) @(posedge aclk);
   endtask
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      prev <= timer_output_pin;
      if (timer_output_pin !== prev)
      begin
         gap <= cyc - last_t;
         last_t <= cyc;
         if (!timer_output_pin)
            hi_w <= cyc - last_t;
      end
   end
endmodule

/* File: test/timer16_event_oneshot_tb.sv */
// Self-checking bench for the timer/event counter.
`timescale 1ns/1ps
`include "tmr_params.svh"
module timer16_event_oneshot_tb;
   import tmr_pkg::*;
   logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata;
   logic awready, wready, bvalid, arready, rvalid, trig, pin, irq_a, irq_b;
   logic [1:0] bresp, rresp;
   logic [33:0] exp_q[$];
   tmr_edge_t edges[3] = '{tmr_edge_rise, tmr_edge_fall, tmr_edge_both};
   int fail_count = 0, tests_run = 0, na = 0, nb = 0, seed = 11, n, k, np, ev;
   always #12.5 aclk = ~aclk;
   tmr_top DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .trigger_input(trig),
      .timer_output_pin(pin), .match_a_irq(irq_a), .match_b_irq(irq_b));
   tmr_pulse_src P (.aclk(aclk), .timer_output_pin(pin), .trigger_input(trig));
   task automatic check(input logic [33:0] seen, input logic [33:0] want);
      tests_run++;
      if (seen !== want)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task automatic close_out;
      $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // A hung handshake ends the run rather than letting later results misalign.
   task automatic tmo;
      if (n >= 100)
      begin
         fail_count++;
         close_out();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      exp_q.push_back({r, 32'h0});
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         n++;
      end while (!bvalid && n < 100);
      bready <= 1'b0;
      tmo();
      @(posedge aclk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      exp_q.push_back({r, d});
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         n++;
      end while (!rvalid && n < 100);
      rready <= 1'b0;
      tmo();
      @(posedge aclk);
   endtask
   task automatic rst;
      aresetn <= 1'b0;
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
   endtask
   always @(posedge aclk)
   begin
      na <= na + int'(irq_a === 1'b1);
      nb <= nb + int'(irq_b === 1'b1);
      if ((bvalid && bready) || (rvalid && rready))
         check(bvalid ? {bresp, 32'h0} : {rresp, rdata}, exp_q.size() ? exp_q.pop_front() : ~34'h0);
   end
   initial
   begin
      rst();
      rd(`TMR_OFF_CCA, 32'h0);
      rd(`TMR_OFF_MODE, 32'h0);
      rd(8'h1C, 32'h0, `TMR_RESP_SLVERR);
      wr(8'h1C, 32'h5, `TMR_RESP_SLVERR);
      k = $random(seed);
      wr(`TMR_OFF_CCA, k);
      rd(`TMR_OFF_CCA, {16'h0, k[15:0]});
      foreach (edges[i])
      begin
         wr(`TMR_OFF_MODE, 32'h0);
         wr(`TMR_OFF_PRESC, {26'h0, edges[i], 4'h3});
         wr(`TMR_OFF_CCA, 32'h3);
         wr(`TMR_OFF_MODE, 32'hC);
         k = na;
         np = 2 + ($unsigned($random(seed)) % 6);
         P.pulse(1, 6);
         repeat (np) P.pulse(4, 4);
         repeat (8) @(posedge aclk);
         ev = np * (edges[i] == tmr_edge_both ? 2 : 1);
         rd(`TMR_OFF_COUNTER, ev % 4);
         check(34'(na - k), 34'(ev / 4));
      end
      rst();
      wr(`TMR_OFF_PRESC, 32'h1);
      wr(`TMR_OFF_CCCTL, 32'h0);
      wr(`TMR_OFF_OUTCTL, 32'h3);
      wr(`TMR_OFF_CCA, 32'h4);
      wr(`TMR_OFF_MODE, 32'hC);
      repeat (70) @(posedge aclk);
      check(34'(P.gap), 34'(5 << `TMR_DIV_MID_LOG2));
      for (int j = 0; j < 2; j++)
      begin
         rst();
         wr(`TMR_OFF_OUTCTL, 32'h21);
         wr(`TMR_OFF_CCA, j ? 32'h8 : 32'h14);
         wr(`TMR_OFF_CCB, j ? 32'h14 : 32'h8);
         wr(`TMR_OFF_MODE, 32'h4);
         wr(`TMR_OFF_OUTCTL, 32'h61);
         repeat (40) @(posedge aclk);
         check(34'(P.hi_w), 34'd12);
      end
      rst();
      wr(`TMR_OFF_PRESC, 32'h10);
      wr(`TMR_OFF_CCCTL, 32'h4);
      wr(`TMR_OFF_MODE, 32'h8);
      k = nb;
      P.pulse(1, 8);
      repeat (3) P.pulse(4, 16);
      check(34'(nb - k), 34'd3);
      rd(`TMR_OFF_CCB, 32'h13);
      // External one-shot in free-run mode; the second edge lands while armed, one cycle before the pulse starts, and must be ignored.
      rst();
      wr(`TMR_OFF_PRESC, 32'h10);
      wr(`TMR_OFF_OUTCTL, 32'h21);
      wr(`TMR_OFF_CCA, 32'h1A);
      wr(`TMR_OFF_CCB, 32'h8);
      wr(`TMR_OFF_MODE, 32'h4);
      P.pulse(4, 4);
      P.pulse(4, 30);
      check(34'(P.hi_w), 34'd18);
      // In match mode overflow needs compare_capture_a at its maximum, and the flag then waits for software.
      rst();
      wr(`TMR_OFF_CCA, 32'hFFFF);
      wr(`TMR_OFF_MODE, 32'hC);
      repeat (65540) @(posedge aclk);
      rd(`TMR_OFF_MODE, 32'hD);
      repeat (50) @(posedge aclk);
      rd(`TMR_OFF_MODE, 32'hD);
      wr(`TMR_OFF_MODE, 32'hC);
      rd(`TMR_OFF_MODE, 32'hC);
      close_out();
   end
endmodule
